/* design/rkw_config_regs.sv */
// rkw_config_regs: mode, keyboard select and wake enable/status registers.
// assumes a classic wishbone master on clk_i and pins that are asynchronous to it.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module rkw_config_regs
    import rkw_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic vbat_por_i,
    input wire logic ce_i,
    // wishbone slave
    input wire rkw_pkg::rkw_wb_req_type wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cmos bank 1 write check
    input wire logic cmos_wr_i,
    input wire logic [6:0] cmos_adr_i,
    output logic cmos_wr_block_o,
    output rkw_pkg::rkw_cmos_map_type cmos_map_o,
    // keyboard controller selections
    output rkw_pkg::rkw_kbd_cfg_type kbd_cfg_o,
    // wake sources and power control
    input wire logic [7:0] wake_pins_i,
    input wire rkw_pkg::rkw_wake_int_type wake_int_i,
    output logic power_on_request_n_o,
    output logic power_button_off_en_o
);
    import rkw_pkg::*;

    // address decode, shared by read and write paths
    function automatic rkw_reg_type decode(input logic [11:0] adr);
        rkw_reg_type r;
        r = RKW_REG_NONE;
        if (adr == 12'(RKW_WIN_RTC + {RKW_IDX_MODE, 2'h0}))
            r = RKW_REG_CMOS;
        else if (adr == 12'(RKW_WIN_KBD + {RKW_IDX_MODE, 2'h0}))
            r = RKW_REG_KBD;
        else if (adr == 12'(RKW_WIN_AUX + {RKW_IDX_WAKE_EN1, 2'h0}))
            r = RKW_REG_EN1;
        else if (adr == 12'(RKW_WIN_AUX + {RKW_IDX_WAKE_EN2, 2'h0}))
            r = RKW_REG_EN2;
        else if (adr == 12'(RKW_WIN_AUX + {RKW_IDX_WAKE_ST1, 2'h0}))
            r = RKW_REG_ST1;
        else if (adr == 12'(RKW_WIN_AUX + {RKW_IDX_WAKE_ST2, 2'h0}))
            r = RKW_REG_ST2;
        return r;
    endfunction

    // pin synchronisers and edge history
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [7:0] fall;

    // two flops per pin, then a third stage for edge detection
    genvar g;
    generate
        for (g = 0; g < RKW_NPINS; g++)
        begin : g_pin
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    sync1_q[g] <= 1'b1;
                    sync2_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end
                else if (ce_i)
                begin
                    sync1_q[g] <= wake_pins_i[g];
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g] <= sync2_q[g];
                end
            end
            assign fall[g] = prev_q[g] & ~sync2_q[g];
        end
    endgenerate

    // register state
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [7:0] cmos_q, cmos_d;
    logic [7:0] kbd_q, kbd_d;
    logic [7:0] en1_q, en1_d;
    logic [7:0] en2_q, en2_d;
    logic [7:0] st1_q, st1_d;
    logic [7:0] st2_q, st2_d;
    logic blk_q, blk_d;
    rkw_cmos_map_type map_q, map_d;
    logic pwr_n_q, pwr_n_d;
    rkw_reg_type sel_reg;
    logic req, wr_now, rd_now;
    logic [7:0] ev1, ev2;

    // a request ends at the edge after ack, where writes and read-clears land
    always_comb
    begin
        req = wb_req_i.cyc & wb_req_i.stb;
        sel_reg = decode(wb_req_i.adr);
        wr_now = req & ack_q & wb_req_i.we & wb_req_i.sel[0];
        rd_now = req & ack_q & ~wb_req_i.we;
        ack_d = req & ~ack_q;
        dat_d = dat_q;
        if (req & ~ack_q)
        begin
            dat_d = 32'h0000_0000;
            case (sel_reg)
                RKW_REG_CMOS: dat_d[7:0] = cmos_q & RKW_MASK_CMOS_MODE;
                // R5 port polarity readback; R9 other indices read zero
                RKW_REG_KBD: dat_d[7:0] = kbd_q & RKW_MASK_KBD_SEL;
                RKW_REG_EN1: dat_d[7:0] = en1_q;
                RKW_REG_EN2: dat_d[7:0] = en2_q & RKW_MASK_WAKE_EN2;
                RKW_REG_ST1: dat_d[7:0] = st1_q;
                RKW_REG_ST2: dat_d[7:0] = st2_q;
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    // configuration next values
    always_comb
    begin
        cmos_d = cmos_q;
        kbd_d = kbd_q;
        en1_d = en1_q;
        en2_d = en2_q;
        if (wr_now)
        begin
            case (sel_reg)
                RKW_REG_CMOS:
                begin
                    // R2 locks only ever set from the bus
                    cmos_d[3:0] = cmos_q[3:0] | wb_req_i.dat[3:0];
                    // R3 bank selection field
                    cmos_d[5:4] = wb_req_i.dat[5:4];
                end
                // R6 R7 R8 keyboard selections stored
                RKW_REG_KBD: kbd_d = wb_req_i.dat[7:0] & RKW_MASK_KBD_SEL;
                // R11 first enable register
                RKW_REG_EN1: en1_d = wb_req_i.dat[7:0];
                // R12 reserved bits held at zero
                RKW_REG_EN2: en2_d = wb_req_i.dat[7:0] & RKW_MASK_WAKE_EN2;
                default: cmos_d = cmos_q;
            endcase
        end
        // R1 R3 map decoded ahead of the flop, so the pins come from a register
        map_d.bank1_lock = cmos_d[3:0];
        map_d.bank0_at_primary = (cmos_d[5:4] == RKW_BANK_BOTH) || (cmos_d[5:4] == RKW_BANK0_ONLY);
        map_d.bank1_at_secondary = (cmos_d[5:4] == RKW_BANK_BOTH) || (cmos_d[5:4] == RKW_BANK1_ONLY);
    end

    // wake events, status and power request
    always_comb
    begin
        ev1 = 8'h00;
        ev1[0] = fall[RKW_PIN_RI1];
        ev1[1] = fall[RKW_PIN_RI2];
        ev1[2] = fall[RKW_PIN_KCLK];
        ev1[3] = fall[RKW_PIN_MCLK];
        ev1[6] = fall[RKW_PIN_IRRX];
        ev1[RKW_EN1_ALARM] = wake_int_i.alarm;
        ev2 = 8'h00;
        ev2[RKW_EN2_RX1] = fall[RKW_PIN_RXD1];
        ev2[RKW_EN2_RX2] = fall[RKW_PIN_RXD2];
        ev2[RKW_EN2_RING] = fall[RKW_PIN_RING];
        ev2[RKW_EN2_CIR] = wake_int_i.cir_wake;
        // R16 read clears, but a new event in that cycle wins
        st1_d = ((rd_now && sel_reg == RKW_REG_ST1) ? 8'h00 : st1_q) | ev1;
        st2_d = ((rd_now && sel_reg == RKW_REG_ST2) ? 8'h00 : st2_q) | ev2;
        // group interrupts are levels, cleared at their source
        st1_d[RKW_EN1_GP1] = wake_int_i.gpint1;
        st1_d[RKW_EN1_GP2] = wake_int_i.gpint2;
        // R10 R13 R14 R17 enabled sources or together, active low out
        pwr_n_d = ~(|(st1_q & en1_q) | |(st2_q & en2_q & 8'h2B));
        // R1 block a bank 1 write into a locked quarter
        blk_d = cmos_wr_i & cmos_q[cmos_adr_i[6:5]];
    end

    // bus side and hard-reset registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            // R2 hard reset is the only clear of the locks
            cmos_q <= RKW_RST_CMOS_MODE;
            kbd_q <= RKW_RST_KBD_SEL;
            blk_q <= 1'b0;
            // decode of the reset mode: bank 1 only, no locks
            map_q <= '{bank0_at_primary: 1'b0, bank1_at_secondary: 1'b1, bank1_lock: 4'h0};
        end
        else if (ce_i)
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            cmos_q <= cmos_d;
            kbd_q <= kbd_d;
            blk_q <= blk_d;
            map_q <= map_d;
        end
    end

    // battery-backed registers survive bus reset
    always_ff @(posedge clk_i)
    begin
        if (vbat_por_i)
        begin
            en1_q <= RKW_RST_WAKE_EN1;
            // R15 power-off by button enabled after power-up
            en2_q <= RKW_RST_WAKE_EN2;
            st1_q <= 8'h00;
            st2_q <= 8'h00;
            pwr_n_q <= 1'b1;
        end
        else if (ce_i)
        begin
            en1_q <= en1_d;
            en2_q <= en2_d;
            st1_q <= st1_d;
            st2_q <= st2_d;
            pwr_n_q <= pwr_n_d;
        end
    end

    // outputs straight from flops
    always_comb
    begin
        wb_ack_o = ack_q;
        wb_dat_o = dat_q;
        cmos_wr_block_o = blk_q;
        power_on_request_n_o = pwr_n_q;
        // R15 button power-off enable
        power_button_off_en_o = en2_q[RKW_EN2_OFF];
        // R1 R3 lock bits and bank map, registered
        cmos_map_o = map_q;
        // R5 R6 R7 R8 keyboard controls
        kbd_cfg_o.port_line_active_high = kbd_q[RKW_KBD_POL];
        kbd_cfg_o.fast_reset_port_en = kbd_q[RKW_KBD_FAST_RST];
        kbd_cfg_o.address_line_20_gate_hw = kbd_q[RKW_KBD_A20];
        kbd_cfg_o.keyboard_cpu_reset_hw = kbd_q[RKW_KBD_CPU_RST];
    end

endmodule // rkw_config_regs

/* design/rkw_pkg.sv */
// rkw_pkg: constants and carrier types for the clock, keyboard and wake config block.
// assumes a 32-bit classic wishbone slave port with byte addresses on a 12-bit bus.
// How it works
// R1 - each of lock bits 0..3 write-protects one 32-byte quarter of cmos bank 1
// R2 - lock bits are sticky against writes; only power-on or hard reset clears them
// R3 - bank field 00/01/10/11 maps bank1-only, both, none, bank0-only
// R4 - software sets secondary base away from 70h before mapping both banks
// R5 - keyboard register bit 7 picks port-line polarity, 0 active low
// R6 - keyboard register bit 2 enables the fast system-control reset port
// R7 - keyboard register bit 1 picks software or hardware address-line-20 gating
// R8 - keyboard register bit 0 picks software or hardware keyboard cpu reset
// R9 - keyboard indices f1h to ffh are reserved and read zero
// R10 - wake enable bit 1 lets its event raise power-on request, 0 blocks
// R11 - first enable register: ri1, ri2, kclk, mclk, gpint1, gpint2, irrx2, alarm
// R12 - second register bits 0/1 enable serial rx wake; bits 2,4,6 reserved
// R13 - second register bit 3 lets the ring pin raise power-on request
// R14 - second register bit 5 lets consumer infrared wake raise power-on request
// R15 - second register bit 7 resets to 1 and enables button power-off
// R16 - latched wake events held in status, cleared by reading status; gpint1/gpint2 status bits follow their levels instead
// R17 - power-on request is the or of all enabled event sources
package rkw_pkg;

    // device windows on the bus, byte address = window + 4 * index
    localparam logic [11:0] RKW_WIN_RTC = 12'h000;
    localparam logic [11:0] RKW_WIN_KBD = 12'h400;
    localparam logic [11:0] RKW_WIN_AUX = 12'h800;

    // printed configuration indices
    localparam logic [7:0] RKW_IDX_WAKE_EN1 = 8'hB0;
    localparam logic [7:0] RKW_IDX_WAKE_EN2 = 8'hB1;
    localparam logic [7:0] RKW_IDX_WAKE_ST1 = 8'hB2;
    localparam logic [7:0] RKW_IDX_WAKE_ST2 = 8'hB3;
    localparam logic [7:0] RKW_IDX_MODE = 8'hF0;

    // reset values
    localparam logic [7:0] RKW_RST_WAKE_EN1 = 8'h00;
    localparam logic [7:0] RKW_RST_WAKE_EN2 = 8'h80;
    localparam logic [7:0] RKW_RST_CMOS_MODE = 8'h00;
    localparam logic [7:0] RKW_RST_KBD_SEL = 8'h00;

    // writable masks, reserved bits read zero
    localparam logic [7:0] RKW_MASK_CMOS_MODE = 8'h3F;
    localparam logic [7:0] RKW_MASK_KBD_SEL = 8'h87;
    localparam logic [7:0] RKW_MASK_WAKE_EN2 = 8'hAB;

    // field positions
    localparam int RKW_BANK_LSB = 4;
    localparam int RKW_KBD_POL = 7;
    localparam int RKW_KBD_FAST_RST = 2;
    localparam int RKW_KBD_A20 = 1;
    localparam int RKW_KBD_CPU_RST = 0;
    localparam int RKW_EN2_RX1 = 0;
    localparam int RKW_EN2_RX2 = 1;
    localparam int RKW_EN2_RING = 3;
    localparam int RKW_EN2_CIR = 5;
    localparam int RKW_EN2_OFF = 7;
    localparam int RKW_EN1_GP1 = 4;
    localparam int RKW_EN1_GP2 = 5;
    localparam int RKW_EN1_ALARM = 7;

    // pin vector positions (all idle high, falling edge is the event)
    localparam int RKW_PIN_RI1 = 0;
    localparam int RKW_PIN_RI2 = 1;
    localparam int RKW_PIN_KCLK = 2;
    localparam int RKW_PIN_MCLK = 3;
    localparam int RKW_PIN_IRRX = 4;
    localparam int RKW_PIN_RXD1 = 5;
    localparam int RKW_PIN_RXD2 = 6;
    localparam int RKW_PIN_RING = 7;
    localparam int RKW_NPINS = 8;

    // bank selection codes
    typedef enum logic [1:0] {
        RKW_BANK1_ONLY = 2'h0,
        RKW_BANK_BOTH = 2'h1,
        RKW_BANK_NONE = 2'h2,
        RKW_BANK0_ONLY = 2'h3
    } rkw_bank_type;

    // register targets of a bus address
    typedef enum logic [2:0] {
        RKW_REG_NONE,
        RKW_REG_CMOS,
        RKW_REG_KBD,
        RKW_REG_EN1,
        RKW_REG_EN2,
        RKW_REG_ST1,
        RKW_REG_ST2
    } rkw_reg_type;

    // wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rkw_wb_req_type;

    // wake sources from internal logic on this clock
    typedef struct packed {
        logic gpint1;
        logic gpint2;
        logic alarm;
        logic cir_wake;
    } rkw_wake_int_type;

    // keyboard controller selections
    typedef struct packed {
        logic port_line_active_high;
        logic fast_reset_port_en;
        logic address_line_20_gate_hw;
        logic keyboard_cpu_reset_hw;
    } rkw_kbd_cfg_type;

    // cmos map outputs
    typedef struct packed {
        logic bank0_at_primary;
        logic bank1_at_secondary;
        logic [3:0] bank1_lock;
    } rkw_cmos_map_type;

endpackage

/* verification/rkw_config_regs_properties.sv */
// rkw_config_regs_properties: port checks bound onto rkw_config_regs.
// assumes one clock and synchronous resets.
`timescale 1ns/1ps
module rkw_config_regs_properties
    import rkw_pkg::*;
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic vbat_por_i,
    input wire logic ce_i,
    // bus
    input wire rkw_pkg::rkw_wb_req_type wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // cmos, keyboard and power
    input wire logic cmos_wr_i,
    input wire logic [6:0] cmos_adr_i,
    input wire logic cmos_wr_block_o,
    input wire rkw_pkg::rkw_cmos_map_type cmos_map_o,
    input wire rkw_pkg::rkw_kbd_cfg_type kbd_cfg_o,
    input wire logic power_button_off_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || vbat_por_i);
    // request taken, and a lane 0 write completing
    sequence s_taken;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i;
    endsequence
    sequence s_wr(logic [11:0] a);
        wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && wb_ack_o && ce_i && wb_req_i.adr == a;
    endsequence
    // handshake: one-cycle ack, lanes above 0 always zero
    a_ack_answer: assert property (s_taken |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper lanes set");
    a_reserved_zero:
        assert property (wb_ack_o && !wb_req_i.we && wb_req_i.adr inside {[12'h7C4:12'h7FC]} |-> wb_dat_o == 32'h0)
        else $error("reserved not zero");
    // $past guard: a hard reset may legally drop locks at the next edge
    a_lock_sticky:
        assert property (!$past(rst_i) |-> ($past(cmos_map_o.bank1_lock) & ~cmos_map_o.bank1_lock) == 4'h0)
        else $error("lock cleared");
    a_lock_block:
        assert property (cmos_wr_i && cmos_map_o.bank1_lock[cmos_adr_i[6:5]] |=> cmos_wr_block_o) else $error("no block");
    a_no_block:
        assert property (!cmos_wr_i |=> !cmos_wr_block_o) else $error("stray block");
    a_bank_map:
        assert property (s_wr(12'h3C0) |=> cmos_map_o.bank0_at_primary == $past(wb_req_i.dat[4])
            && cmos_map_o.bank1_at_secondary == !$past(wb_req_i.dat[5])) else $error("bank map wrong");
    a_kbd_select:
        assert property (s_wr(12'h7C0) |=> kbd_cfg_o == {$past(wb_req_i.dat[7]), $past(wb_req_i.dat[2]),
            $past(wb_req_i.dat[1]), $past(wb_req_i.dat[0])}) else $error("keyboard select wrong");
    a_off_enable:
        assert property (s_wr(12'hAC4) |=> power_button_off_en_o == $past(wb_req_i.dat[7])) else $error("off enable");
endmodule // rkw_config_regs_properties
bind rkw_config_regs rkw_config_regs_properties i_props (.clk_i, .rst_i, .vbat_por_i, .ce_i, .wb_req_i, .wb_dat_o,
    .wb_ack_o, .cmos_wr_i, .cmos_adr_i, .cmos_wr_block_o, .cmos_map_o, .kbd_cfg_o, .power_button_off_en_o);

/* verification/rkw_host_model.sv */
// rkw_host_model: host software acting as a classic wishbone master.
// assumes the slave answers with ack in its own time.
`timescale 1ns/1ps
module rkw_host_model
    import rkw_pkg::*;
(
    // clock
    input wire logic clk_i,
    // wishbone master side
    output rkw_pkg::rkw_wb_req_type wb_req_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // idle bus at time zero
    initial
    begin
        wb_req_o = '0;
    end
    // one classic cycle, held until ack; only the bench watchdog ends a hang
    // software is to keep any secondary base off 70h before mapping both banks; xfer only runs bus cycles and sets no base
    task automatic xfer(input logic [11:0] a, input logic we, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
        // look between edges so an ack launched at an edge is never raced
        do
        begin
            @(negedge clk_i);
        end
        while (wb_ack_i !== 1'b1);
        // the edge where ack is high: write lands, read data taken, then release
        @(posedge clk_i);
        q = wb_dat_i;
        // released lines show the inverse so stale values never pass
        wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~a, sel: 4'h0, dat: {24'hFFFFFF, ~d}};
    endtask
endmodule // rkw_host_model

/* verification/rkw_config_regs_tb_top.sv */
// rkw_config_regs_tb_top: directed bench for rkw_config_regs.
// assumes the host model as bus master; the bench drives pins and resets.
`timescale 1ns/1ps
module rkw_config_regs_tb_top;
    import rkw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic vbat_por_i = 1'b1;
    logic cmos_wr_i = 1'b0;
    logic [6:0] cmos_adr_i = 7'h00;
    logic [7:0] pins = 8'hFF;
    logic [3:0] wint = 4'h0;
    logic [7:0] kb [4] = '{8'h01, 8'h02, 8'h04, 8'h80};
    rkw_wb_req_type req;
    logic [31:0] rdat;
    logic ack, blk, req_n, off_en;
    rkw_cmos_map_type map;
    rkw_kbd_cfg_type kcfg;
    int mismatches = 0;
    int checks_done = 0;
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    rkw_host_model i_host (.clk_i(clk_i), .wb_req_o(req), .wb_dat_i(rdat), .wb_ack_i(ack));
    rkw_config_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .vbat_por_i(vbat_por_i), .ce_i(1'b1), .wb_req_i(req),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cmos_wr_i(cmos_wr_i), .cmos_adr_i(cmos_adr_i), .cmos_wr_block_o(blk),
        .cmos_map_o(map), .kbd_cfg_o(kcfg), .wake_pins_i(pins), .wake_int_i(wint), .power_on_request_n_o(req_n),
        .power_button_off_en_o(off_en));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    // bus accesses; the negedge lets the write's updates land before any look
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        i_host.xfer(a, 1'b1, d, q);
        @(negedge clk_i);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        i_host.xfer(a, 1'b0, 8'h00, q);
        chk(q, exp);
        @(negedge clk_i);
    endtask
    // one wake source: p below 8 is a pin, else internal bit p-8
    task automatic wake(input int p, input logic [11:0] ea, input logic [7:0] m, input logic [7:0] ev, input bit lat);
        wr(ea, ev);
        @(posedge clk_i);
        if (p < 8)
            pins[p] <= 1'b0;
        else
            wint[p - 8] <= 1'b1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk(32'(req_n), ((ev & m) != 8'h00) ? 32'h0 : 32'h1);
        @(posedge clk_i);
        pins <= 8'hFF;
        wint <= 4'h0;
        rdc(ea + 12'h008, lat ? 32'(m) : 32'h0);
        rdc(ea + 12'h008, 32'h0);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(32'(req_n), 32'h1);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
    // directed sequence
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        vbat_por_i <= 1'b0;
        @(negedge clk_i);
        chk(32'(off_en), 32'h1);
        rdc(12'h3C0, 32'h00);
        rdc(12'h7C0, 32'h00);
        rdc(12'hAC4, 32'h80);
        for (int c = 0; c < 4; c++)
        begin
            wr(12'h3C0, 8'(c * 16 + 5));
            chk(32'({map.bank0_at_primary, map.bank1_at_secondary}), 32'({c[0], ~c[1]}));
        end
        wr(12'h3C0, 8'h00);
        rdc(12'h3C0, 32'h05);
        for (int q = 0; q < 4; q++)
        begin
            @(posedge clk_i);
            cmos_wr_i <= 1'b1;
            cmos_adr_i <= 7'(q * 32 + 31);
            @(posedge clk_i);
            cmos_wr_i <= 1'b0;
            @(negedge clk_i);
            chk(32'(blk), (q % 2 == 0) ? 32'h1 : 32'h0);
        end
        wr(12'h3C0, 8'hFF);
        rdc(12'h3C0, 32'h3F);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(12'h3C0, 32'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h7C0, kb[i] | 8'h78);
            chk(32'(kcfg), 32'(1 << i));
        end
        rdc(12'h7C0, 32'h80);
        rdc(12'h7C4, 32'h00);
        rdc(12'h7FC, 32'h00);
        rdc(12'hFFC, 32'h00);
        wr(12'hAC4, 8'hFF);
        rdc(12'hAC4, 32'hAB);
        @(posedge clk_i);
        vbat_por_i <= 1'b1;
        @(posedge clk_i);
        vbat_por_i <= 1'b0;
        rdc(12'hAC4, 32'h80);
        wake(0, 12'hAC0, 8'h01, 8'h01, 1'b1);
        wake(2, 12'hAC0, 8'h04, 8'hFB, 1'b1);
        wake(4, 12'hAC0, 8'h40, 8'h40, 1'b1);
        wake(9, 12'hAC0, 8'h80, 8'h80, 1'b1);
        wake(11, 12'hAC0, 8'h10, 8'h10, 1'b0);
        wake(5, 12'hAC4, 8'h01, 8'h01, 1'b1);
        wake(7, 12'hAC4, 8'h08, 8'h08, 1'b1);
        wake(7, 12'hAC4, 8'h08, 8'h00, 1'b1);
        wake(8, 12'hAC4, 8'h20, 8'h20, 1'b1);
        give_verdict();
    end
endmodule // rkw_config_regs_tb_top
